// ---- rtl/conv_start_pkg.sv ----
// Shared constants and types for the conversion start and synchronisation block
package conv_start_pkg;

  // Clock of this block, 10 MHz
  localparam int unsigned CLK_PERIOD_NS = 100;

  // Front-end system clock period, rounded to whole ns (1 / 4.608 MHz)
  localparam int unsigned SYS_CLK_PERIOD_NS = 217;

  // Setup delay that only the first reading after a start carries, 2 system clocks
  localparam int unsigned FIXED_DELAY_NS = 2 * SYS_CLK_PERIOD_NS;

  // A least time, so it rounds up
  localparam int unsigned FIXED_CYCLES =
    (FIXED_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Default conversion time, fastest data rate (288 ksps)
  localparam int unsigned CONV_TIME_NS = 3472;

  // A longest time, so it rounds down
  localparam int unsigned CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;

  // Shortest start pulse the host must give, 2 system clocks
  localparam int unsigned START_PULSE_MIN_NS = 2 * SYS_CLK_PERIOD_NS;

  // Width of the delay and conversion down counter
  localparam int unsigned CNT_W = 16;

  // Width of the channel pointer
  localparam int unsigned CHAN_W = 4;

  // Clock source select value that picks the external master clock
  localparam logic [1:0] CLK_SRC_EXTERNAL = 2'h1;

  // Conversion command codes, each picks one reading mode
  typedef enum logic [2:0] {
    one_chan_one_shot_mode   = 3'h0,
    one_chan_continuous_mode = 3'h1,
    multi_chan_one_shot_mode = 3'h2,
    multi_chan_multi_mode    = 3'h3,
    multi_chan_continuous_mode = 3'h4
  } read_mode_t;

  // Highest legal command code
  localparam logic [2:0] CMD_CODE_MAX = 3'h4;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h1,
    ST_SETUP   = 3'h2,
    ST_CONVERT = 3'h4
  } seq_state_t;

endpackage

// ---- rtl/start_edge_sync.sv ----
// Two-flop synchroniser and rising-edge detector for the start pulse pin
`timescale 1ns/1ps
`default_nettype none

module start_edge_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Asynchronous pin
  input wire logic i_pin,
  // One-cycle pulse on each rising edge
  output logic o_rise
);

  logic meta_q, meta_d;
  logic sync_q, sync_d;
  logic last_q, last_d;
  logic rise_q, rise_d;

  ////////////////////////////////////////////////////////////////////////
  // Only sync_q reads the first flop; every pulse of one clock or more
  // is caught, well inside the 2 system clock minimum
  always_comb begin
    meta_d = i_pin;
    sync_d = meta_q;
    last_d = sync_q;
    rise_d = sync_q & ~last_q;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
      rise_q <= rise_d;
    end
  end

  assign o_rise = rise_q;

endmodule

`default_nettype wire

// ---- rtl/conversion_start_sync.sv ----
// Conversion start selection, reading sequencer, ready output and clock options
//
// Operation
// - Select bit one: start on pin rising edge
// - Pin edge during conversion aborts and restarts
// - Pin mode: commands only choose reading mode
// - Select bit zero: ignore start pin
// - Command mode: command picks mode and starts
// - Pin start works in every reading mode
// - Five commands map to five reading modes
// - Shared start line gives same-edge start
// - Ready rises at each completed reading
// - Clock select one: use external master clock
// - Clock-out enable drives system clock on pin; here pin nine toggles at half the block clock
// - Reading completes at ready rising edge
`timescale 1ns/1ps
`default_nettype none

module conversion_start_sync #(
  parameter int unsigned FIXED_CNT = conv_start_pkg::FIXED_CYCLES,
  parameter int unsigned CONV_CNT = conv_start_pkg::CONV_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Configuration from system_config_word0
  input wire logic i_pin_trigger_sel,
  input wire logic [1:0] i_clock_source_select,
  input wire logic i_clock_out_en,
  input wire logic [conv_start_pkg::CHAN_W-1:0] i_last_chan,
  // Conversion command, pulse at last serial-clock falling edge
  input wire logic i_cmd_valid,
  input wire logic [2:0] i_conversion_command,
  // Start pulse pin, asynchronous
  input wire logic i_start_pin,
  // Sequencer status
  output logic o_busy,
  output logic [2:0] o_read_mode,
  output logic [conv_start_pkg::CHAN_W-1:0] o_chan_ptr,
  output logic o_conv_start,
  output logic o_abort,
  output logic o_reading_ready_out,
  // Clock options
  output logic o_use_external_clock,
  output logic o_general_pin_nine
);
  import conv_start_pkg::*;

  localparam logic [CNT_W-1:0] FIXED_LOAD = CNT_W'(FIXED_CNT - 1);
  localparam logic [CNT_W-1:0] CONV_LOAD = CNT_W'(CONV_CNT - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CHAN_W-1:0] CHAN_ZERO = '0;
  localparam logic [CHAN_W-1:0] CHAN_ONE = CHAN_W'(1);

  logic pin_rise;
  logic cmd_legal;
  logic start_evt;

  seq_state_t state_q, state_d;
  read_mode_t mode_q, mode_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CHAN_W-1:0] chan_q, chan_d;
  logic start_q, start_d;
  logic abort_q, abort_d;
  logic ready_q, ready_d;
  logic ext_q, ext_d;
  logic pin9_q, pin9_d;
  logic busy_q, busy_d;

  ////////////////////////////////////////////////////////////////////////
  // Start pin capture; fixed latency keeps devices on one line aligned
  start_edge_sync u_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_pin(i_start_pin),
    .o_rise(pin_rise)
  );

  // Start source choice; the unselected source is dropped
  always_comb begin
    cmd_legal = i_cmd_valid && (i_conversion_command <= CMD_CODE_MAX);
    if (i_pin_trigger_sel) begin
      start_evt = pin_rise;
    end else begin
      start_evt = cmd_legal;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reading sequencer next state
  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    cnt_d = cnt_q;
    chan_d = chan_q;
    start_d = 1'b0;
    abort_d = 1'b0;
    ready_d = 1'b0;
    // A command always chooses the mode, whatever the trigger source
    if (cmd_legal) begin
      mode_d = read_mode_t'(i_conversion_command);
    end
    if (start_evt) begin
      // A new start wins over any reading in flight
      abort_d = (state_q != ST_IDLE);
      state_d = ST_SETUP;
      cnt_d = FIXED_LOAD;
      chan_d = CHAN_ZERO;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          cnt_d = CNT_ZERO;
        end
        ST_SETUP: begin
          if (cnt_q == CNT_ZERO) begin
            state_d = ST_CONVERT;
            cnt_d = CONV_LOAD;
            start_d = 1'b1;
          end else begin
            cnt_d = cnt_q - CNT_W'(1);
          end
        end
        ST_CONVERT: begin
          if (cnt_q == CNT_ZERO) begin
            ready_d = 1'b1;
            // Later readings skip the setup delay
            cnt_d = CONV_LOAD;
            start_d = 1'b1;
            unique case (mode_q)
              one_chan_one_shot_mode, multi_chan_one_shot_mode: begin
                state_d = ST_IDLE;
                start_d = 1'b0;
              end
              one_chan_continuous_mode: begin
                state_d = ST_CONVERT;
              end
              multi_chan_multi_mode: begin
                if (chan_q == i_last_chan) begin
                  state_d = ST_IDLE;
                  start_d = 1'b0;
                end else begin
                  chan_d = chan_q + CHAN_ONE;
                end
              end
              multi_chan_continuous_mode: begin
                chan_d = (chan_q == i_last_chan) ? CHAN_ZERO : chan_q + CHAN_ONE;
              end
            endcase
          end else begin
            cnt_d = cnt_q - CNT_W'(1);
          end
        end
      endcase
    end
    // Busy follows the next state, so the output is a plain register
    busy_d = (state_d != ST_IDLE);
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_q <= ST_IDLE;
      busy_q <= 1'b0;
      mode_q <= one_chan_one_shot_mode;
      cnt_q <= CNT_ZERO;
      chan_q <= CHAN_ZERO;
      start_q <= 1'b0;
      abort_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      state_q <= state_d;
      busy_q <= busy_d;
      mode_q <= mode_d;
      cnt_q <= cnt_d;
      chan_q <= chan_d;
      start_q <= start_d;
      abort_q <= abort_d;
      ready_q <= ready_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock options; pin nine carries a half-rate stand-in for the system clock
  always_comb begin
    ext_d = (i_clock_source_select == CLK_SRC_EXTERNAL);
    pin9_d = i_clock_out_en ? ~pin9_q : 1'b0;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ext_q <= 1'b0;
      pin9_q <= 1'b0;
    end else begin
      ext_q <= ext_d;
      pin9_q <= pin9_d;
    end
  end

  assign o_busy = busy_q;
  assign o_read_mode = mode_q;
  assign o_chan_ptr = chan_q;
  assign o_conv_start = start_q;
  assign o_abort = abort_q;
  assign o_reading_ready_out = ready_q;
  assign o_use_external_clock = ext_q;
  assign o_general_pin_nine = pin9_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  sequence conv_end_s;
    state_q == ST_CONVERT && cnt_q == CNT_ZERO && !start_evt;
  endsequence

  sequence ready_blip_s;
    o_reading_ready_out ##1 !o_reading_ready_out;
  endsequence

  pin_start_a: assert property (
    i_pin_trigger_sel && pin_rise |=> state_q == ST_SETUP && cnt_q == FIXED_LOAD
  ) else $error("pin edge did not start a reading");

  pin_abort_a: assert property (
    i_pin_trigger_sel && pin_rise && state_q == ST_CONVERT |=> o_abort && o_busy
  ) else $error("pin edge did not abort and restart");

  cmd_mode_only_a: assert property (
    i_pin_trigger_sel && cmd_legal && !pin_rise && state_q == ST_IDLE
      |=> state_q == ST_IDLE && o_read_mode == $past(i_conversion_command)
  ) else $error("command started a reading in pin mode");

  pin_ignored_a: assert property (
    !i_pin_trigger_sel && !i_cmd_valid && state_q == ST_IDLE |=> !o_busy
  ) else $error("start pin acted in command mode");

  cmd_start_a: assert property (
    !i_pin_trigger_sel && cmd_legal
      |=> state_q == ST_SETUP && o_read_mode == $past(i_conversion_command)
  ) else $error("command did not start its reading");

  first_conv_a: assert property (
    state_q == ST_SETUP && cnt_q == CNT_ZERO && !start_evt
      |=> o_conv_start && state_q == ST_CONVERT
  ) else $error("setup delay did not lead to conversion");

  continuous_a: assert property (
    conv_end_s and (mode_q == one_chan_continuous_mode)
      |=> state_q == ST_CONVERT && cnt_q == CONV_LOAD
  ) else $error("continuous mode stopped");

  single_end_a: assert property (
    conv_end_s and (mode_q == one_chan_one_shot_mode) |=> state_q == ST_IDLE
  ) else $error("single reading did not return to idle");

  ready_edge_a: assert property (
    conv_end_s |=> ready_blip_s
  ) else $error("ready did not pulse at reading end");

  ext_clock_a: assert property (
    i_clock_source_select == CLK_SRC_EXTERNAL |=> o_use_external_clock
  ) else $error("external clock not selected");

  pin_nine_a: assert property (
    i_clock_out_en && $past(i_clock_out_en)
      |-> o_general_pin_nine != $past(o_general_pin_nine)
  ) else $error("system clock not driven on pin nine");

endmodule

`default_nettype wire

// ---- tb/host_model.sv ----
// Host stand-in driving conversion commands and the start pulse pin
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input wire logic i_clk,
  // Command strobe, code and start pin
  output logic o_cmd_valid,
  output logic [2:0] o_code,
  output logic o_start_pin
);
  import conv_start_pkg::*;
  // Least high time of a pulse in bench clocks, rounded up
  localparam int HOLD = (START_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  int held = 0;
  initial begin
    o_cmd_valid = 1'b0;
    o_code = 3'h7;
    o_start_pin = 1'b0;
  end
  // Cycles the pin has stood high
  always @(posedge i_clk) begin
    held <= o_start_pin ? held + 1 : 0;
  end
  // One-cycle strobe; the released code line shows junk, not the old value
  task automatic send_cmd(input logic [2:0] c);
    @(posedge i_clk);
    o_cmd_valid <= 1'b1;
    o_code <= c;
    @(posedge i_clk);
    o_cmd_valid <= 1'b0;
    o_code <= ~c;
  endtask
  // Pin stays low two cycles before each rise
  task automatic pin_rise();
    repeat (2) @(posedge i_clk);
    o_start_pin <= 1'b1;
  endtask
  // Never drop the pin before the least pulse width has passed
  task automatic pin_fall();
    while (held < HOLD) @(posedge i_clk);
    @(posedge i_clk);
    o_start_pin <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- tb/conversion_start_sync_tb.sv ----
// Self-checking bench for the conversion start block
`timescale 1ns/1ps
`default_nettype none
module conversion_start_sync_tb;
  import conv_start_pkg::*;
  // Short counts keep the run brief
  localparam int FIXED = 2;
  localparam int CONV = 4;
  logic i_clk = 1'b0, i_srst = 1'b1, i_sel = 1'b0, i_clk_en = 1'b0;
  logic [1:0] i_src = 2'h0;
  logic [3:0] i_last = 4'h2;
  logic [3:0] chan;
  logic cmd_valid, start_pin, busy, conv_start, abort, ready, use_ext, pin9;
  logic [2:0] code, mode;
  int err_total = 0, tests_run = 0, cyc = 0;
  //////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    forever #50 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      summarize();
    end
  end
  host_model i_host (.i_clk(i_clk), .o_cmd_valid(cmd_valid), .o_code(code),
    .o_start_pin(start_pin));
  conversion_start_sync #(.FIXED_CNT(FIXED), .CONV_CNT(CONV)) i_dut (
    .i_clk(i_clk), .i_srst(i_srst), .i_pin_trigger_sel(i_sel),
    .i_clock_source_select(i_src), .i_clock_out_en(i_clk_en), .i_last_chan(i_last),
    .i_cmd_valid(cmd_valid), .i_conversion_command(code), .i_start_pin(start_pin),
    .o_busy(busy), .o_read_mode(mode), .o_chan_ptr(chan), .o_conv_start(conv_start),
    .o_abort(abort), .o_reading_ready_out(ready), .o_use_external_clock(use_ext),
    .o_general_pin_nine(pin9));
  //////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic do_reset(input logic s);
    @(posedge i_clk);
    i_srst <= 1'b1;
    repeat (12) @(posedge i_clk);
    i_srst <= 1'b0;
    i_sel <= s;
  endtask
  // Edges until the picked pulse shows: 0 start, 1 ready, 2 abort
  task automatic wait_for(input int w, output int n);
    logic s;
    n = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
      s = (w == 0) ? conv_start : (w == 1) ? ready : abort;
    end while (s !== 1'b1 && n < 60);
  endtask
  task automatic idle_for(input int k);
    repeat (k) begin
      @(posedge i_clk);
      #1;
      chk("idle_busy", busy, 1'b0);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // One reading mode under one trigger source
  task automatic run_mode(input logic s, input logic [2:0] c);
    int n, nr;
    logic cont;
    cont = (c == 3'h1 || c == 3'h4);
    nr = (c == 3'h3) ? 3 : cont ? 2 : 1;
    do_reset(s);
    i_host.send_cmd(c);
    if (s) begin
      idle_for(8);
      i_host.pin_rise();
      wait_for(0, n);
      chk("pin_lat", n, 4 + FIXED);
    end else begin
      wait_for(0, n);
      chk("cmd_lat", n, FIXED);
    end
    chk("mode", mode, c);
    wait_for(1, n);
    chk("ready_lat", n, CONV);
    for (int k = 1; k < nr; k++) begin
      wait_for(1, n);
      chk("period", n, CONV);
    end
    chk("busy_end", busy, cont);
    chk("chan", chan, (c == 3'h3) ? i_last : (c == 3'h4) ? nr : 0);
    if (s) i_host.pin_fall();
    if (cont) begin
      if (s) begin
        i_host.pin_rise();
        wait_for(2, n);
      end else begin
        // The abort pulse stands in the cycle right after the take edge
        i_host.send_cmd(c);
        #1 n = abort ? 0 : 60;
      end
      chk("abort_lat", n, s ? 4 : 0);
      wait_for(0, n);
      chk("restart", n, FIXED);
      if (s) i_host.pin_fall();
    end
    $display("done mode %0d sel %0d", c, s);
  endtask
  // Pin ignored in command mode, unknown codes refused
  task automatic t_ignore();
    do_reset(1'b0);
    i_host.pin_rise();
    idle_for(12);
    i_host.pin_fall();
    i_host.send_cmd(3'h5);
    idle_for(10);
    $display("done ignore");
  endtask
  // Clock source decode and clock output pin
  task automatic t_clocks();
    logic a;
    for (int v = 0; v < 4; v++) begin
      @(posedge i_clk);
      i_src <= v[1:0];
      @(posedge i_clk);
      #1 chk("ext_clk", use_ext, v == 1);
    end
    @(posedge i_clk);
    i_clk_en <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1 a = pin9;
    @(posedge i_clk);
    #1 chk("pin9_tgl", pin9, !a);
    @(posedge i_clk);
    i_clk_en <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1 chk("pin9_off", pin9, 1'b0);
    $display("done clocks");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Verdict
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 5; c++) run_mode(s[0], c[2:0]);
    end
    t_ignore();
    t_clocks();
    summarize();
  end
endmodule
`default_nettype wire
